// ===== eli_pkg.sv
// package for the lpi idle wait timer: indirect register map, resets, timing
// assumes a 200 MHz core clock and byte-wide register access
package eli_pkg;

	// direct byte registers of the indirect access mechanism
	localparam logic [7:0] ADDR_IND_CTRL = 8'h6e;	// table select / space
	localparam logic [7:0] ADDR_IND_OFFS = 8'h6f;	// byte offset in space
	localparam logic [7:0] ADDR_IND_DATA = 8'ha0;	// data byte window

	// indirect control byte fields
	localparam int TABLE_MSB = 7;
	localparam int TABLE_LSB = 5;
	localparam int SPACE_MSB = 3;
	localparam int SPACE_LSB = 0;
	localparam logic [2:0] TABLE_EEE = 3'h1;	// eee table
	localparam logic [3:0] SPACE_GLOBAL = 4'h0;	// global register space

	// byte offsets inside the eee global space
	localparam logic [7:0] OFFS_QM_HI = 8'h30;	// buffer control, upper byte
	localparam logic [7:0] OFFS_QM_LO = 8'h31;	// buffer control, lower byte
	localparam logic [7:0] OFFS_WAIT_HI = 8'h32;	// wait time bits 15:8
	localparam logic [7:0] OFFS_WAIT_LO = 8'h33;	// wait time bits 7:0
	localparam logic [7:0] OFFS_DIAG_HI = 8'h34;	// pcs diagnostic, upper byte
	localparam logic [7:0] OFFS_DIAG_LO = 8'h35;	// pcs diagnostic, lower byte

	// field positions and reset / read-only values
	localparam int TERM_EN_BIT = 7;	// terminate-on-traffic enable in 0x31
	localparam logic [7:0] QM_HI_RO = 8'h40;	// reserved upper byte
	localparam logic [6:0] QM_LO_RO = 7'h10;	// reserved bits 6:0
	localparam logic [7:0] DIAG_HI_RO = 8'h68;	// reserved fields 0x6 / 0x8
	localparam logic [7:0] DIAG_LO_RO = 8'h00;
	localparam logic TERM_EN_RESET = 1'b0;
	localparam logic [15:0] WAIT_RESET = 16'h03e8;	// 1000 steps = 1.3 s
	localparam logic [15:0] WAIT_PRINTED = 16'h0010;	// printed field value, unused

	// timing: one wait step of 1.3 ms at a 5 ns clock
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned STEP_TIME_US = 1300;
	// microseconds to picoseconds before dividing by the clock period: 260000 cycles per step
	localparam int unsigned STEP_CYCLES = (STEP_TIME_US * 1000000) / CLK_PERIOD_PS;

	// register access request carried as one bundle
	typedef struct packed {
		logic wr;	// write strobe, one cycle
		logic rd;	// read strobe, one cycle
		logic [7:0] addr;	// direct byte address
		logic [7:0] data;	// write data
	} eli_req_t;

endpackage

// ===== eli_port_timer.sv
// one port's idle counter and lpi request flop
// assumes tick is a one-cycle pulse per wait step, all inputs on clk
`timescale 1ns/1ps
module eli_port_timer
	import eli_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// shared controls
	input wire logic tick,
	input wire logic runEn,
	input wire logic termEn,
	input wire logic [15:0] waitTime,
	// port status
	input wire logic queueEmpty,
	input wire logic trafficIn,
	// results
	output logic [15:0] idleCount,
	output logic lpiReq
);

	logic [15:0] cnt_q;	// whole steps spent empty
	logic [15:0] cnt_d;
	logic req_q;
	logic req_d;
	logic restart;	// any cause that ends the current empty interval

	// a non-empty queue, traffic with termination on, or a disabled mode restart the wait
	assign restart = !runEn || !queueEmpty || (termEn && trafficIn);

	// next count saturates so an idle port never wraps back below the wait time
	always_comb begin
		cnt_d = cnt_q;
		if (restart) begin
			cnt_d = 16'h0000;
		end else if (tick && cnt_q != 16'hffff) begin
			cnt_d = cnt_q + 16'h0001;
		end
		req_d = !restart && (cnt_d > waitTime);
	end

	// counter register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// request register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_q <= 1'b0;
		end else begin
			req_q <= req_d;
		end
	end

	assign idleCount = cnt_q;
	assign lpiReq = req_q;

endmodule

// ===== eli_idle_wait_timer.sv
// top of the lpi idle wait timer: indirect byte registers, step divider, per-port timers
// assumes register strobes and port status come from logic on clk
//
// What this block does
// - Request lpi after queue empty beyond wait.
// - Timer active only in fast energy-efficient mode.
// - One shared wait value for all ports.
// - Wait counts in 1.3 ms steps, 16 bits.
// - Default wait 1.3 s; printed 0x10 conflicts.
// - Data byte at 0xa0 reads/writes selected byte.
// - Traffic withdraws request when termination enabled.
`timescale 1ns/1ps
module eli_idle_wait_timer
	import eli_pkg::*;
#(
	parameter int unsigned NUM_PORTS = 4,
	parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register access
	input wire eli_req_t regReq,
	output logic [7:0] regRdData,
	output logic regRdValid,
	// mode and port status
	input wire logic energyEfficientFastMode,
	input wire logic [NUM_PORTS-1:0] transmitQueueEmpty,
	input wire logic [NUM_PORTS-1:0] trafficIn,
	// lpi requests
	output logic [NUM_PORTS-1:0] lpiReq
);

	////////////////////////////////////////////////////////////////////////////////
	// indirect register file

	localparam int STEP_W = $clog2(STEP_CYCLES_P + 1);

	logic [7:0] indCtrl_q;	// table select / space byte
	logic [7:0] indOffs_q;	// selected byte offset
	logic [15:0] waitTime_q;	// shared wait, in steps
	logic termEn_q;	// withdraw request on input traffic
	logic [7:0] rdData_q;
	logic rdValid_q;
	logic eeeSel;	// control byte points at the eee global space
	logic dataWr;
	logic [7:0] indRdByte;
	logic [STEP_W-1:0] stepCnt_q;
	logic tick_q;	// one-cycle pulse each wait step
	logic [15:0] idleCount [NUM_PORTS];

	// only the eee global space is implemented here; other tables read zero
	assign eeeSel = (indCtrl_q[TABLE_MSB:TABLE_LSB] == TABLE_EEE)
		&& (indCtrl_q[SPACE_MSB:SPACE_LSB] == SPACE_GLOBAL);
	assign dataWr = regReq.wr && (regReq.addr == ADDR_IND_DATA) && eeeSel;

	// direct control and offset bytes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			indCtrl_q <= 8'h00;
			indOffs_q <= 8'h00;
		end else if (regReq.wr) begin
			if (regReq.addr == ADDR_IND_CTRL) begin
				indCtrl_q <= regReq.data;
			end
			if (regReq.addr == ADDR_IND_OFFS) begin
				indOffs_q <= regReq.data;
			end
		end
	end

	// wait time and termination enable, written through the data window
	// bytes land one at a time, so a timer may briefly see a half-updated wait
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			waitTime_q <= WAIT_RESET;
			termEn_q <= TERM_EN_RESET;
		end else if (dataWr) begin
			case (indOffs_q)
				OFFS_WAIT_HI: begin
					waitTime_q[15:8] <= regReq.data;
				end
				OFFS_WAIT_LO: begin
					waitTime_q[7:0] <= regReq.data;
				end
				OFFS_QM_LO: begin
					termEn_q <= regReq.data[TERM_EN_BIT];
				end
				default: begin
					// reserved and unmapped offsets ignore writes
				end
			endcase
		end
	end

	// byte visible through the data window at the selected offset
	always_comb begin
		indRdByte = 8'h00;
		if (eeeSel) begin
			case (indOffs_q)
				OFFS_QM_HI: indRdByte = QM_HI_RO;
				OFFS_QM_LO: indRdByte = {termEn_q, QM_LO_RO};
				OFFS_WAIT_HI: indRdByte = waitTime_q[15:8];
				OFFS_WAIT_LO: indRdByte = waitTime_q[7:0];
				OFFS_DIAG_HI: indRdByte = DIAG_HI_RO;
				OFFS_DIAG_LO: indRdByte = DIAG_LO_RO;
				default: indRdByte = 8'h00;
			endcase
		end
	end

	// read data is registered: valid one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdData_q <= 8'h00;
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= regReq.rd;
			if (regReq.rd) begin
				case (regReq.addr)
					ADDR_IND_CTRL: rdData_q <= indCtrl_q;
					ADDR_IND_OFFS: rdData_q <= indOffs_q;
					ADDR_IND_DATA: rdData_q <= indRdByte;
					default: rdData_q <= 8'h00;
				endcase
			end
		end
	end

	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;

	////////////////////////////////////////////////////////////////////////////////
	// step divider: one enable pulse per 1.3 ms

	// divider runs freely; the first step of an interval may be short by up to one step
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stepCnt_q <= '0;
			tick_q <= 1'b0;
		end else if (stepCnt_q == STEP_W'(STEP_CYCLES_P - 1)) begin
			stepCnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			stepCnt_q <= stepCnt_q + STEP_W'(1);
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-port timers sharing one wait value

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		eli_port_timer u_timer (
			.clk(clk),
			.rst_n(rst_n),
			.tick(tick_q),
			.runEn(energyEfficientFastMode),
			.termEn(termEn_q),
			.waitTime(waitTime_q),
			.queueEmpty(transmitQueueEmpty[p]),
			.trafficIn(trafficIn[p]),
			.idleCount(idleCount[p]),
			.lpiReq(lpiReq[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	AST_REQ_NEEDS_MODE: assert property (@(posedge clk) disable iff (!rst_n)
		|lpiReq |-> $past(energyEfficientFastMode))
		else $error("lpi request without fast energy-efficient mode");

	AST_REQ_NEEDS_EMPTY: assert property (@(posedge clk) disable iff (!rst_n)
		lpiReq[0] |-> $past(transmitQueueEmpty[0]) && $past(idleCount[0]) >= $past(waitTime_q))
		else $error("lpi request before wait elapsed");

	AST_RISE_PAST_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(lpiReq[NUM_PORTS-1]) |-> idleCount[NUM_PORTS-1] > $past(waitTime_q))
		else $error("request rose with idle count not beyond shared wait");

	AST_TERMINATE: assert property (@(posedge clk) disable iff (!rst_n)
		termEn_q && trafficIn[0] |=> !lpiReq[0] && idleCount[0] == 16'h0000)
		else $error("traffic did not withdraw lpi request");

	AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
		!transmitQueueEmpty[0] |=> idleCount[0] == 16'h0000 ##1 idleCount[0] <= 16'h0001)
		else $error("idle counter not restarted");

	AST_STEP_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		tick_q |=> !tick_q && stepCnt_q == STEP_W'(1))
		else $error("step pulse malformed");

	AST_WAIT_RESET: assert property (@(posedge clk)
		!$past(rst_n) && rst_n |-> waitTime_q == WAIT_RESET)
		else $error("wait time reset value wrong");

	AST_WR_HI: assert property (@(posedge clk) disable iff (!rst_n)
		dataWr && indOffs_q == OFFS_WAIT_HI |=> waitTime_q[15:8] == $past(regReq.data))
		else $error("upper wait byte not written");

	AST_RD_LO: assert property (@(posedge clk) disable iff (!rst_n)
		regReq.rd && regReq.addr == ADDR_IND_DATA && eeeSel && indOffs_q == OFFS_WAIT_LO
		|=> regRdValid && regRdData == $past(waitTime_q[7:0]))
		else $error("lower wait byte read wrong");

	AST_SEL_GUARD: assert property (@(posedge clk) disable iff (!rst_n)
		regReq.wr && regReq.addr == ADDR_IND_DATA && !eeeSel |=> $stable(waitTime_q))
		else $error("write outside eee space changed wait");

	// with termination off, traffic on an empty port must leave a standing request alone
	AST_TRAFFIC_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
		lpiReq[0] && !termEn_q && trafficIn[0] && transmitQueueEmpty[0]
		&& energyEfficientFastMode && $stable(waitTime_q) |=> lpiReq[0])
		else $error("traffic withdrew request with termination off");

	AST_MODE_OFF_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		!energyEfficientFastMode |=> !lpiReq[0] && idleCount[0] == 16'h0000)
		else $error("counter or request survived mode off");

	AST_DIV_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		stepCnt_q <= STEP_W'(STEP_CYCLES_P - 1))
		else $error("step divider beyond its period");

endmodule

// ===== tb_eli_idle_wait_timer.sv
// self-checking bench for the lpi idle wait timer: indirect registers and port timers
// assumes a short step divider (4 cycles) so wait steps pass quickly
`timescale 1ns/1ps
module tb_eli_idle_wait_timer;
	import eli_pkg::*;
	localparam int NP = 4;	// ports under test
	localparam int SC = 4;	// cycles per wait step
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	eli_req_t regReq = '0;	// register strobes, driven at falling edge
	logic [7:0] regRdData;
	logic regRdValid;
	logic energyEfficientFastMode = 1'b0;
	logic [NP-1:0] transmitQueueEmpty = '0;
	logic [NP-1:0] trafficIn = '0;
	logic [NP-1:0] lpiReq;
	int errors = 0;
	int n_compared = 0;
	logic [15:0] lfsr = 16'h6be1;	// seed 27617
	logic [7:0] w;	// wait steps in use
	logic [NP-1:0] m;	// random port mask
	eli_idle_wait_timer #(.NUM_PORTS(NP), .STEP_CYCLES_P(SC)) u_eli_idle_wait_timer (
		.clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
		.regRdValid(regRdValid), .energyEfficientFastMode(energyEfficientFastMode),
		.transmitQueueEmpty(transmitQueueEmpty), .trafficIn(trafficIn), .lpiReq(lpiReq));
	always #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	// shift register stepped on every draw, so the run repeats exactly
	function automatic logic [15:0] next_rand();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// requests expected once the ports in hit have been restarted
	function automatic logic [15:0] drop_exp(logic [NP-1:0] hit);
		logic [15:0] e;
		e = '0;
		e[NP-1:0] = ~hit;
		return e;
	endfunction
	// one compare for every kind of value
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one-cycle write strobe; an idle cycle follows so strobes never merge
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge clk);
		regReq = '0;
	endtask
	// read strobe; valid stands one cycle only, so look at the next falling edge
	task automatic rd_chk(string n, logic [7:0] a, logic [7:0] exp);
		@(negedge clk);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge clk);
		chk("regRdValid", 16'h1, 16'(regRdValid));
		chk(n, 16'(exp), 16'(regRdData));
		regReq = '0;
	endtask
	// wait for a request pattern under a bound, and check it did not come early
	task automatic rise(logic [NP-1:0] mask, int lo, int hi);
		int t;
		t = 0;
		while (lpiReq !== mask && t < hi) begin
			@(negedge clk);
			t++;
		end
		chk("lpiReq", 16'(mask), 16'(lpiReq));
		chk("notEarly", 16'h1, 16'(t >= lo));
	endtask
	task automatic finish_test();
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#50000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk("lpiAfterReset", 16'h0, 16'(lpiReq));
		// window is closed until the eee global space is selected
		wr(ADDR_IND_DATA, 8'h55);
		rd_chk("closedWindow", ADDR_IND_DATA, 8'h00);
		wr(ADDR_IND_CTRL, {TABLE_EEE, 1'b0, SPACE_GLOBAL});
		wr(ADDR_IND_OFFS, OFFS_WAIT_HI);
		rd_chk("waitHiReset", ADDR_IND_DATA, 8'h03);
		wr(ADDR_IND_OFFS, OFFS_WAIT_LO);
		rd_chk("waitLoReset", ADDR_IND_DATA, 8'he8);
		// reserved diagnostic byte ignores writes
		wr(ADDR_IND_OFFS, OFFS_DIAG_HI);
		wr(ADDR_IND_DATA, 8'hff);
		rd_chk("diagHi", ADDR_IND_DATA, 8'h68);
		for (int k = 0; k < 2; k++) begin
			w = 8'(next_rand() % 3) + 8'h1;
			wr(ADDR_IND_OFFS, OFFS_WAIT_HI);
			wr(ADDR_IND_DATA, 8'h00);
			wr(ADDR_IND_OFFS, OFFS_WAIT_LO);
			wr(ADDR_IND_DATA, w);
			rd_chk("waitLo", ADDR_IND_DATA, w);
			// all ports go empty together and must request together
			energyEfficientFastMode = 1'b1;
			transmitQueueEmpty = '0;
			repeat (2) @(negedge clk);
			transmitQueueEmpty = '1;
			rise('1, int'(w) * SC, (int'(w) + 1) * SC + 3);
			// a random set of queues refills: counters restart, requests drop
			m = NP'(next_rand()) | 4'h1;
			transmitQueueEmpty = ~m;
			repeat (2) @(negedge clk);
			chk("refillDrop", drop_exp(m), 16'(lpiReq));
			transmitQueueEmpty = '1;
			rise('1, int'(w) * SC, (int'(w) + 1) * SC + 3);
		end
		// terminate-on-traffic enabled: traffic withdraws the request
		wr(ADDR_IND_OFFS, OFFS_QM_LO);
		wr(ADDR_IND_DATA, 8'h80);
		rd_chk("termEnSet", ADDR_IND_DATA, 8'h90);
		m = NP'(next_rand()) | 4'h1;
		trafficIn = m;
		repeat (2) @(negedge clk);
		chk("trafficDrop", drop_exp(m), 16'(lpiReq));
		trafficIn = '0;
		rise('1, int'(w) * SC, (int'(w) + 1) * SC + 3);
		// with the enable clear, traffic leaves the requests alone
		wr(ADDR_IND_DATA, 8'h00);
		trafficIn = '1;
		repeat (3) @(negedge clk);
		chk("trafficKeep", 16'hf, 16'(lpiReq));
		trafficIn = '0;
		// mode off: requests fall and none comes back
		energyEfficientFastMode = 1'b0;
		repeat (2) @(negedge clk);
		chk("modeOffDrop", 16'h0, 16'(lpiReq));
		repeat (10 * SC) @(negedge clk);
		chk("modeOffIdle", 16'h0, 16'(lpiReq));
		// a second reset mid-run brings every register back to its reset value
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk("lpiAfterReset2", 16'h0, 16'(lpiReq));
		rd_chk("ctrlAfterReset", ADDR_IND_CTRL, 8'h00);
		rd_chk("offsAfterReset", ADDR_IND_OFFS, 8'h00);
		wr(ADDR_IND_CTRL, {TABLE_EEE, 1'b0, SPACE_GLOBAL});
		wr(ADDR_IND_OFFS, OFFS_QM_LO);
		rd_chk("termEnReset", ADDR_IND_DATA, {TERM_EN_RESET, QM_LO_RO});
		wr(ADDR_IND_OFFS, OFFS_QM_HI);
		rd_chk("qmHiReserved", ADDR_IND_DATA, QM_HI_RO);
		wr(ADDR_IND_OFFS, OFFS_WAIT_LO);
		rd_chk("waitLoAgain", ADDR_IND_DATA, WAIT_RESET[7:0]);
		finish_test();
	end
endmodule
